// ### rtl/fsn_clk_notify.sv
// Clock notification and encoder monitor registers on Avalon-MM
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
module fsn_clk_notify
  import fsn_pkg::*;
#(
  parameter logic [7:0] FREQ_MAX = FREQ_MAX_DEF
)
(
  // Clock and reset
  input  wire logic                        core_clk_in,
  input  wire logic                        resetn_in,
  // Avalon-MM slave
  input  wire logic [fsn_pkg::ADDR_W-1:0]  avs_address_in,
  input  wire logic                        avs_read_in,
  input  wire logic                        avs_write_in,
  input  wire logic [fsn_pkg::DATA_W-1:0]  avs_writedata_in,
  input  wire logic [3:0]                  avs_byteenable_in,
  output logic      [fsn_pkg::DATA_W-1:0]  avs_readdata_out,
  output logic                             avs_waitrequest_out,
  // Sequencer status and mode
  input  wire logic                        sequencer_ready_flag_in,
  input  wire logic                        cf_pe_mode_in,
  input  wire logic                        df_pe_mode_in,
  // Encoder outputs
  input  wire logic [fsn_pkg::CF_ECC_W-1:0] cf_ecc_in,
  input  wire logic [fsn_pkg::DF_ECC_W-1:0] df_ecc_in,
  // Operation timer
  input  wire logic                        op_start_in,
  input  wire logic [fsn_pkg::US_W-1:0]    op_dur_us_in,
  output logic                             op_busy_out,
  output logic                             op_done_out,
  // Notified frequency
  output logic      [fsn_pkg::FREQ_W-1:0]  sequencer_freq_mhz_out
);
  import fsn_pkg::*;

  logic              waitreq_q;
  logic [DATA_W-1:0] rdata_q;
  logic [FREQ_W-1:0] freq_q;
  logic [MON_W-1:0]  mon_q;
  logic              req;
  logic              fire;
  logic              key_ok;
  logic              wr_freq;

  fsn_timer_if tif ();

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] b);
    hit = (a == b);
  endfunction

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // One wait cycle, then a single-cycle answer
  assign req    = avs_read_in || avs_write_in;
  assign fire   = req && !waitreq_q;
  assign key_ok = (avs_writedata_in[KEY_MSB:KEY_LSB] == UNLOCK_KEY);
  assign wr_freq = fire && avs_write_in
                   && hit(avs_address_in, CLK_NOTIFY_ADDR)
                   && ((avs_byteenable_in & BE_LOW_HALF) == BE_LOW_HALF)
                   && key_ok && sequencer_ready_flag_in;

  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
      waitreq_q <= 1'b1;
    else
      waitreq_q <= !(req && waitreq_q);
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
      rdata_q <= RD_UNMAPPED;
    else if (avs_read_in && waitreq_q)
    begin
      // Key byte never reads back
      if (hit(avs_address_in, CLK_NOTIFY_ADDR))
        rdata_q <= {{(DATA_W-FREQ_W){1'b0}}, freq_q};
      else if (hit(avs_address_in, ECC_MON_ADDR))
        rdata_q <= {{(DATA_W-MON_W){1'b0}}, mon_q};
      else
        rdata_q <= RD_UNMAPPED;
    end
  end

  // ----------------------------------------------------------------
  // Frequency notification
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
      freq_q <= FREQ_MAX;
    else if (wr_freq)
      freq_q <= avs_writedata_in[FREQ_W-1:0];
  end

  // ----------------------------------------------------------------
  // Encoder monitor
  // ----------------------------------------------------------------
  // encoder output on low bits
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
      mon_q <= MON_RESET;
    else if (cf_pe_mode_in)
      mon_q <= {MON_RSVD_HI, MON_RSVD_B9, cf_ecc_in};
    else if (df_pe_mode_in)
      mon_q <= {MON_RSVD_HI, MON_RSVD_B9, DF_FIXED_HI, df_ecc_in};
    // Outside P/E mode the encoder is idle; show reset value
    else
      mon_q <= MON_RESET;
  end

  // ----------------------------------------------------------------
  // Operation timer
  // ----------------------------------------------------------------
  // timer runs on notified MHz
  assign tif.freq_mhz = freq_q;
  assign tif.start    = op_start_in;
  assign tif.dur_us   = op_dur_us_in;

  fsn_op_timer u_timer (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .tif         (tif)
  );

  assign avs_readdata_out       = rdata_q;
  assign avs_waitrequest_out    = waitreq_q;
  assign sequencer_freq_mhz_out = freq_q;
  assign op_busy_out            = tif.busy;
  assign op_done_out            = tif.done;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_answer;
    !waitreq_q ##1 waitreq_q;
  endsequence

  a_bus_one_wait: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    (req && waitreq_q) |=> s_answer)
    else $error("bus answer not one wait then one cycle");

  a_bad_key_hold: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    (fire && avs_write_in && !key_ok) |=> $stable(freq_q))
    else $error("frequency changed without unlock key");

  a_key_write_load: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    (fire && avs_write_in && key_ok && sequencer_ready_flag_in
     && avs_byteenable_in == 4'hF
     && avs_address_in == CLK_NOTIFY_ADDR)
    |=> freq_q == $past(avs_writedata_in[7:0]))
    else $error("unlocked write did not load frequency");

  a_not_ready_hold: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    (fire && !sequencer_ready_flag_in) |=> $stable(freq_q))
    else $error("frequency changed while sequencer busy");

  a_freq_reset_max: assert property (@(posedge core_clk_in)
    !resetn_in |=> freq_q == FREQ_MAX)
    else $error("frequency not at maximum after reset");

  a_cf_mon_follow: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    cf_pe_mode_in |=> mon_q[8:0] == $past(cf_ecc_in))
    else $error("monitor does not follow code-flash encoder");

  a_df_mon_follow: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    (df_pe_mode_in && !cf_pe_mode_in)
    |=> mon_q[8:7] == 2'h3 && mon_q[6:0] == $past(df_ecc_in))
    else $error("monitor wrong in data-flash mode");

  a_mon_rsvd_ones: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    (avs_read_in && waitreq_q && avs_address_in == ECC_MON_ADDR)
    |=> avs_readdata_out[15:10] == 6'h3F && !avs_waitrequest_out)
    else $error("monitor reserved bits not ones on read");
endmodule

// ### rtl/fsn_op_timer.sv
// Operation timer that turns microseconds into clocks by the notified MHz
`timescale 1ns/1ps
module fsn_op_timer
  import fsn_pkg::*;
(
  // Clock and reset
  input  wire logic  core_clk_in,
  input  wire logic  resetn_in,
  // Timer link
  fsn_timer_if.tmr   tif
);
  fsn_tstate_e       state_q;
  logic [FREQ_W-1:0] freq_lat_q;
  logic [FREQ_W-1:0] pre_q;
  logic [US_W-1:0]   us_q;
  logic              done_q;
  logic              tick;

  // ----------------------------------------------------------------
  // Microsecond prescaler
  // ----------------------------------------------------------------
  // tick every freq clocks
  assign tick = (pre_q + 8'h01 >= freq_lat_q);

  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      state_q    <= FSN_T_IDLE;
      freq_lat_q <= FREQ_MAX_DEF;
      pre_q      <= '0;
      us_q       <= '0;
      done_q     <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      unique case (state_q)
        FSN_T_IDLE:
        begin
          if (tif.start)
          begin
            state_q    <= FSN_T_RUN;
            freq_lat_q <= tif.freq_mhz;
            pre_q      <= '0;
            us_q       <= tif.dur_us;
          end
        end
        FSN_T_RUN:
        begin
          if (tick)
          begin
            pre_q <= '0;
            // Zero duration still spends one microsecond
            if (us_q <= 16'h0001)
            begin
              state_q <= FSN_T_IDLE;
              done_q  <= 1'b1;
            end
            else
              us_q <= us_q - 16'h0001;
          end
          else
            pre_q <= pre_q + 8'h01;
        end
      endcase
    end
  end

  assign tif.busy = (state_q == FSN_T_RUN);
  assign tif.done = done_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_done_on_tick: assert property (@(posedge core_clk_in)
    disable iff (!resetn_in)
    done_q |-> $past(state_q == FSN_T_RUN) && $past(tick))
    else $error("timer done without a finished microsecond");
endmodule

// ### rtl/fsn_pkg.sv
// Constants and types for the flash sequencer clock notification block
package fsn_pkg;
  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 32;
  localparam int          DATA_W          = 32;
  localparam logic [31:0] CLK_NOTIFY_ADDR = 32'hFFA1_00E4;
  localparam logic [31:0] ECC_MON_ADDR    = 32'hFFA1_0100;
  localparam logic [3:0]  BE_LOW_HALF     = 4'h3;
  localparam logic [31:0] RD_UNMAPPED     = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Clock notification layout
  // ----------------------------------------------------------------
  localparam int          KEY_MSB         = 15;
  localparam int          KEY_LSB         = 8;
  localparam int          FREQ_W          = 8;
  localparam logic [7:0]  UNLOCK_KEY      = 8'h1E;
  localparam logic [7:0]  FREQ_MAX_DEF    = 8'h50;
  // ----------------------------------------------------------------
  // Encoder monitor layout
  // ----------------------------------------------------------------
  localparam int          MON_W           = 16;
  localparam int          CF_ECC_W        = 9;
  localparam int          DF_ECC_W        = 7;
  localparam logic [15:0] MON_RESET       = 16'hFFFF;
  localparam logic [1:0]  DF_FIXED_HI     = 2'h3;
  localparam logic [5:0]  MON_RSVD_HI     = 6'h3F;
  localparam logic        MON_RSVD_B9     = 1'h0;
  // ----------------------------------------------------------------
  // Timer
  // ----------------------------------------------------------------
  localparam int          US_W            = 16;
  typedef enum logic [0:0] {
    FSN_T_IDLE = 1'b0,
    FSN_T_RUN  = 1'b1
  } fsn_tstate_e;
endpackage

// ### rtl/fsn_timer_if.sv
// Link between register block and operation timer
`timescale 1ns/1ps
interface fsn_timer_if;
  import fsn_pkg::*;
  logic [FREQ_W-1:0] freq_mhz;
  logic              start;
  logic [US_W-1:0]   dur_us;
  logic              busy;
  logic              done;
  modport ctrl (output freq_mhz, output start, output dur_us,
                input busy, input done);
  modport tmr  (input freq_mhz, input start, input dur_us,
                output busy, output done);
endinterface

// ### verification/fsn_clk_notify_test.sv
// Self-checking bench for the clock notification and monitor block
`timescale 1ns/1ps
module fsn_clk_notify_test;
  import fsn_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic              clk, resetn, rd_en, wr_en, rdy, cf_mode, df_mode;
  logic              wait_req, op_start, busy, done;
  logic [31:0]       addr, wdata, rdata;
  logic [3:0]        be;
  logic [8:0]        cf_ecc;
  logic [6:0]        df_ecc;
  logic [15:0]       op_dur;
  logic [7:0]        freq;
  int                n_fail, n_compared;
  localparam logic [7:0] BAD_KEYS [3] = '{8'h00, 8'h1F, 8'hE1};

  fsn_clk_notify dut_u (
    .core_clk_in(clk), .resetn_in(resetn), .avs_address_in(addr),
    .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_req), .sequencer_ready_flag_in(rdy),
    .cf_pe_mode_in(cf_mode), .df_pe_mode_in(df_mode), .cf_ecc_in(cf_ecc),
    .df_ecc_in(df_ecc), .op_start_in(op_start), .op_dur_us_in(op_dur),
    .op_busy_out(busy), .op_done_out(done), .sequencer_freq_mhz_out(freq)
  );

  always #2.5 clk = ~clk;
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Holds the request until waitrequest is seen low at an edge
  // One idle edge after, so registered results have settled
  task automatic bus(input logic [31:0] a, input logic wr,
                     input logic [31:0] wd, output logic [31:0] rd);
    int i;
    @(posedge clk);
    addr  <= a;
    wr_en <= wr;
    rd_en <= !wr;
    wdata <= wd;
    for (i = 0; i < 16; i++)
    begin
      @(posedge clk);
      if (wait_req === 1'b0)
        break;
    end
    rd = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge clk);
    if (i == 16)
    begin
      n_fail++;
      $display("Error waitrequest expected 0 seen %b", wait_req);
      final_report();
    end
  endtask

  // Counts busy cycles up to the done pulse
  task automatic run_op(input logic [7:0] f, input logic [15:0] dur,
                        input int exp);
    logic [31:0] d;
    int          i;
    int          cnt;
    bus(CLK_NOTIFY_ADDR, 1'b1, {16'h0, UNLOCK_KEY, f}, d);
    @(posedge clk);
    op_start <= 1'b1;
    op_dur   <= dur;
    @(posedge clk);
    op_start <= 1'b0;
    cnt = 0;
    for (i = 0; i < 1000; i++)
    begin
      @(posedge clk);
      if (done === 1'b1)
        break;
      if (busy === 1'b1)
        cnt++;
    end
    if (i == 1000)
    begin
      n_fail++;
      $display("Error done expected 1 seen %b", done);
      final_report();
    end
    else
      check("busy cycles", 32'(exp), 32'(cnt));
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    check("freq reset", {24'h0, FREQ_MAX_DEF}, {24'h0, freq});
    bus(CLK_NOTIFY_ADDR, 1'b0, 32'h0, d);
    check("notify read", {24'h0, FREQ_MAX_DEF}, d);
    bus(ECC_MON_ADDR, 1'b0, 32'h0, d);
    // Bit 9 masked, its value is not fixed
    check("monitor reset", 32'h0000_FDFF, d & 32'hFFFF_FDFF);
    $display("test reset done");
  endtask

  task automatic t_key();
    logic [31:0] d;
    for (int k = 0; k < 3; k++)
    begin
      bus(CLK_NOTIFY_ADDR, 1'b1, {16'h0, BAD_KEYS[k], 8'h24}, d);
      check("freq bad key", {24'h0, FREQ_MAX_DEF}, {24'h0, freq});
    end
    // 35.9 MHz rounded up to 36
    bus(CLK_NOTIFY_ADDR, 1'b1, {16'h0, UNLOCK_KEY, 8'h24}, d);
    check("freq good key", 32'h24, {24'h0, freq});
    bus(CLK_NOTIFY_ADDR, 1'b0, 32'h0, d);
    check("notify readback", 32'h24, d);
    @(posedge clk);
    rdy <= 1'b0;
    bus(CLK_NOTIFY_ADDR, 1'b1, {16'h0, UNLOCK_KEY, 8'h10}, d);
    check("freq not ready", 32'h24, {24'h0, freq});
    @(posedge clk);
    rdy <= 1'b1;
    bus(CLK_NOTIFY_ADDR, 1'b1, {16'h0, UNLOCK_KEY, 8'h03}, d);
    check("freq ready", 32'h03, {24'h0, freq});
    $display("test key done");
  endtask

  task automatic t_monitor();
    logic [31:0] d;
    @(posedge clk);
    cf_mode <= 1'b1;
    cf_ecc  <= 9'h0A5;
    df_ecc  <= 7'h2A;
    bus(ECC_MON_ADDR, 1'b0, 32'h0, d);
    check("monitor code", 32'h0000_FCA5, d & 32'hFFFF_FDFF);
    @(posedge clk);
    cf_mode <= 1'b0;
    df_mode <= 1'b1;
    bus(ECC_MON_ADDR, 1'b1, 32'h0000_0000, d);
    bus(ECC_MON_ADDR, 1'b0, 32'h0, d);
    check("monitor data", 32'h0000_FDAA, d & 32'hFFFF_FDFF);
    bus(32'hFFA1_0104, 1'b0, 32'h0, d);
    check("unmapped read", RD_UNMAPPED, d);
    $display("test monitor done");
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    {rd_en, wr_en, cf_mode, df_mode, op_start} = 5'h00;
    rdy = 1'b1;
    be = 4'hF;
    addr = 32'h0;
    wdata = 32'h0;
    cf_ecc = 9'h000;
    df_ecc = 7'h00;
    op_dur = 16'h0000;
    n_fail = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_key();
    t_monitor();
    // Unmodulated 200 MHz clock: notify at or above it, never below
    run_op(8'hC8, 16'h0002, 400);
    run_op(8'hFF, 16'h0001, 255);
    $display("test timer done");
    final_report();
  end
endmodule
